// File: nic_cfg.svh
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH

// ****************************************************************
// Source counts and poll order
// ****************************************************************
`define NIC_NUM_SRC     15
`define NIC_NUM_FLAG    17
// Poll index of the sources whose flags hardware clears on vectoring
`define NIC_SRC_EXT0    4'h0
`define NIC_SRC_T0      4'h3
`define NIC_SRC_EXT1    4'h6
`define NIC_SRC_T1      4'h9
// Sources able to end idle mode, one bit per poll index
`define NIC_WAKE_MASK   15'h124B

// ****************************************************************
// Enable and level register bit positions
// ****************************************************************
`define NIC_A_EXT0      0
`define NIC_A_T0        1
`define NIC_A_EXT1      2
`define NIC_A_T1        3
`define NIC_A_UART      4
`define NIC_A_TWOWIRE   5
`define NIC_A_ADC       6
`define NIC_A_GATE      7
`define NIC_B_CAP0      0
`define NIC_B_CAP1      1
`define NIC_B_CAP2      2
`define NIC_B_CAP3      3
`define NIC_B_CMP0      4
`define NIC_B_CMP1      5
`define NIC_B_CMP2      6
`define NIC_B_T2OVF     7

// ****************************************************************
// Reset values and vector defaults
// ****************************************************************
`define NIC_RST_FLAGS   17'h00000
`define NIC_RST_PIN     1'h1
// Vector table defaults, values arbitrary, integrator overrides them
`define NIC_VEC_BASE    16'h0100
`define NIC_VEC_STEP    16'h0008

`endif

// File: nic_pkg.sv
package nic_pkg;

   // ****************************************************************
   // Flag identifiers, used as the software write selector
   // ****************************************************************
   typedef enum logic [4:0] {
      NIC_FLG_EXT0  = 5'h00,
      NIC_FLG_EXT1  = 5'h01,
      NIC_FLG_T0    = 5'h02,
      NIC_FLG_T1    = 5'h03,
      NIC_FLG_URX   = 5'h04,
      NIC_FLG_UTX   = 5'h05,
      NIC_FLG_TW    = 5'h06,
      NIC_FLG_ADC   = 5'h07,
      NIC_FLG_SEC   = 5'h08,
      NIC_FLG_CAP0  = 5'h09,
      NIC_FLG_CAP1  = 5'h0A,
      NIC_FLG_CAP2  = 5'h0B,
      NIC_FLG_CAP3  = 5'h0C,
      NIC_FLG_CMP0  = 5'h0D,
      NIC_FLG_CMP1  = 5'h0E,
      NIC_FLG_CMP2  = 5'h0F,
      NIC_FLG_T2OVF = 5'h10
   } nic_flag_e;

   // ****************************************************************
   // Grouped carriers
   // ****************************************************************
   // One-cycle hardware events from the peripherals
   typedef struct packed {
      logic       t0_roll;
      logic       t1_roll;
      logic       uart_rx;
      logic       uart_tx;
      logic       twowire_evt;
      logic       adc_done;
      logic       one_hz;
      logic [3:0] t2_cap;
      logic [2:0] t2_cmp;
      logic       t2_ovf;
   } nic_hw_evt_s;

   // Software write of one flag
   typedef struct packed {
      logic      wr;
      nic_flag_e sel;
      logic      val;
   } nic_sw_wr_s;

   // Acknowledged call
   typedef struct packed {
      logic        hi;
      logic [3:0]  src;
      logic [15:0] vec;
   } nic_call_s;

endpackage

// File: nic_pin_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// Two-flop synchroniser for asynchronous pins
// ****************************************************************
module nic_pin_sync
#(
   parameter int          W        = 1,
   parameter logic        RST_VAL  = 1'b1
)
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Pins and synchronised copies
   input  wire logic [W-1:0] pin_raw,
   output logic      [W-1:0] pin_sync
);

   logic [W-1:0] meta_reg;   // First stage, read only by second stage

   // Two stages, pins idle high
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= {W{RST_VAL}};
         pin_sync <= {W{RST_VAL}};
      end
      else
      begin
         meta_reg <= pin_raw;
         pin_sync <= meta_reg;
      end
   end

endmodule

// File: nic_irq_ctrl.sv
// How it works
// R1: Fifteen request sources feed the poll.
// R2: Per-input select: level or falling edge.
// R3: Vectoring clears external flag only if edge.
// R4: Level flag follows low pin, drops high.
// R5: Level source holds until taken, releases.
// R6: External request pins are active low.
// R7: Timer requests come from overflow events.
// R8: Vectoring clears timer overflow flags.
// R9: Eight Timer 2 flags, software clears only.
// R10: UART request ORs receive and transmit.
// R11: Two-wire event flag, software clears only.
// R12: ADC flag, software clears, cannot set.
// R13: Seconds flag ORed onto external one.
// R14: Software writes act like hardware events.
// R15: Only six sources end idle mode.
// R16: Individual enables plus global gate.
// R17: One level bit per source, 1 high.
// R18: High preempts low, high never preempted.
// R19: Higher level wins, then poll order.
// R20: Fixed poll order, external zero first.
// R21: Sample at phase strobe, poll next.
// R22: Set enabled sample issues long call.
// R23: Block on active level, non-final cycle.
// R24: Block during return or enable access.
// R25: No memory of blocked past requests.
// R26: Return clears the active level flop.
// R27: Capture pins as extra edge requests.
// R28: Each source gets distinct vector address.
`timescale 1ns/1ps
`include "nic_cfg.svh"

module nic_irq_ctrl
#(
   parameter logic [15:0] VEC_BASE = `NIC_VEC_BASE,
   parameter logic [15:0] VEC_STEP = `NIC_VEC_STEP
)
(
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // Pins, active low external requests and capture inputs
   input  wire logic                ext_zero_request_pin,
   input  wire logic                ext_one_request_pin,
   input  wire logic [3:0]          capture_input_pin,
   // Configuration
   input  wire logic                ext0_edge_select,
   input  wire logic                ext1_edge_select,
   input  wire logic [3:0]          cap_rise_en,
   input  wire logic [3:0]          cap_fall_en,
   input  wire logic [7:0]          irq_enable_reg_a,
   input  wire logic [7:0]          irq_enable_reg_b,
   input  wire logic [7:0]          irq_level_reg_a,
   input  wire logic [7:0]          irq_level_reg_b,
   // Peripheral events and software flag writes
   input  wire nic_pkg::nic_hw_evt_s hw_evt,
   input  wire nic_pkg::nic_sw_wr_s  sw_wr,
   // CPU timing
   input  wire logic                flag_sample_phase,
   input  wire logic                cpu_final_cycle,
   input  wire logic                cpu_blocking_instr,
   input  wire logic                return_from_irq_instr,
   // Outputs
   output nic_pkg::nic_call_s       call_info_reg,
   output logic                     hw_long_call_reg,
   output logic [16:0]              flags_reg,
   output logic                     act_hi_reg,
   output logic                     act_lo_reg,
   output logic                     idle_wake_reg
);
   import nic_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Reorder two enable-style registers into poll order
   function automatic logic [14:0] map_src(input logic [7:0] a, input logic [7:0] b);
      map_src = {b[`NIC_B_T2OVF], b[`NIC_B_CAP3], a[`NIC_A_UART], b[`NIC_B_CMP2],
                 b[`NIC_B_CAP2], a[`NIC_A_T1], b[`NIC_B_CMP1], b[`NIC_B_CAP1],
                 a[`NIC_A_EXT1], b[`NIC_B_CMP0], b[`NIC_B_CAP0], a[`NIC_A_T0],
                 a[`NIC_A_ADC], a[`NIC_A_TWOWIRE], a[`NIC_A_EXT0]};
   endfunction

   // Lowest set index, found bit on top
   function automatic logic [4:0] first_idx(input logic [14:0] v);
      first_idx = 5'h00;
      for (int i = `NIC_NUM_SRC - 1; i >= 0; i--)
      begin
         if (v[i])
            first_idx = {1'b1, 4'(i)};
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [5:0] pins_sync;   // {capture[3:0], ext1, ext0}, synchronised
   logic [5:0] pins_prev;   // One cycle older copy for edges

   nic_pin_sync #(.W(6), .RST_VAL(`NIC_RST_PIN)) u_sync
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin_raw  ({capture_input_pin, ext_one_request_pin, ext_zero_request_pin}),
      .pin_sync (pins_sync)
   );

   // Delay line for edge detection, read from the second stage only
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pins_prev <= {6{`NIC_RST_PIN}};
      else
         pins_prev <= pins_sync;
   end

   logic [1:0] ext_fall;   // Falling edge on external pins
   logic [3:0] cap_edge;   // Selected edge on capture pins
   assign ext_fall = pins_prev[1:0] & ~pins_sync[1:0];                                         // R6
   assign cap_edge = (cap_rise_en & ~pins_prev[5:2] & pins_sync[5:2])
                   | (cap_fall_en & pins_prev[5:2] & ~pins_sync[5:2]);                          // R27

   // ****************************************************************
   // Poll, arbitration and call decision
   // ****************************************************************
   logic [14:0] sample_reg;     // Requests caught at the phase strobe
   logic [14:0] req_now;        // Live requests in poll order
   logic [14:0] en_src;         // Individual enables in poll order
   logic [14:0] hi_src;         // Level bits in poll order
   logic [4:0]  hi_pick;        // Winner among high requests
   logic [4:0]  lo_pick;        // Winner among low requests
   logic        gate;           // Global gate
   logic        call_next;      // Call issued this edge
   logic [3:0]  pick_src;       // Chosen source
   logic        clr_ext0;       // Vector clears external zero flag
   logic        clr_ext1;       // Vector clears external one flag
   logic        clr_t0;         // Vector clears timer zero flag
   logic        clr_t1;         // Vector clears timer one flag

   // Requests in fixed poll order                                                             // R20
   assign req_now = {flags_reg[NIC_FLG_T2OVF], flags_reg[NIC_FLG_CAP3],
                     flags_reg[NIC_FLG_URX] | flags_reg[NIC_FLG_UTX],                         // R10
                     flags_reg[NIC_FLG_CMP2], flags_reg[NIC_FLG_CAP2], flags_reg[NIC_FLG_T1],
                     flags_reg[NIC_FLG_CMP1], flags_reg[NIC_FLG_CAP1],
                     flags_reg[NIC_FLG_EXT1] | flags_reg[NIC_FLG_SEC],                        // R13
                     flags_reg[NIC_FLG_CMP0], flags_reg[NIC_FLG_CAP0], flags_reg[NIC_FLG_T0],
                     flags_reg[NIC_FLG_ADC], flags_reg[NIC_FLG_TW], flags_reg[NIC_FLG_EXT0]};  // R1

   assign gate    = irq_enable_reg_a[`NIC_A_GATE];
   assign en_src  = map_src(irq_enable_reg_a, irq_enable_reg_b) & {15{gate}};                  // R16
   assign hi_src  = map_src(irq_level_reg_a, irq_level_reg_b);                                 // R17
   assign hi_pick = first_idx(sample_reg & en_src & hi_src);                                   // R19
   assign lo_pick = first_idx(sample_reg & en_src & ~hi_src);                                  // R19

   // High may preempt low; nothing preempts high; only at instruction end
   assign call_next = cpu_final_cycle && !cpu_blocking_instr && !act_hi_reg                    // R23 R24
                   && (hi_pick[4] || (lo_pick[4] && !act_lo_reg));                             // R18 R22
   assign pick_src  = hi_pick[4] ? hi_pick[3:0] : lo_pick[3:0];

   // Hardware clears only edge external and timer flags on vectoring
   assign clr_ext0 = call_next && pick_src == `NIC_SRC_EXT0 && ext0_edge_select;               // R3
   assign clr_ext1 = call_next && pick_src == `NIC_SRC_EXT1 && ext1_edge_select;               // R3
   assign clr_t0   = call_next && pick_src == `NIC_SRC_T0;                                     // R8
   assign clr_t1   = call_next && pick_src == `NIC_SRC_T1;                                     // R8

   // Samples refresh every strobe, so a blocked request that has gone is forgotten
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sample_reg <= 15'h0000;
      else if (flag_sample_phase)
         sample_reg <= req_now;                                                                // R21 R25
   end

   // ****************************************************************
   // Request flags
   // ****************************************************************
   logic [16:0] hw_set;   // Hardware set terms per flag
   logic [16:0] hw_clr;   // Hardware clear terms per flag
   logic [16:0] sw_set;   // Software set terms per flag
   logic [16:0] sw_clr;   // Software clear terms per flag

   // Gather set and clear terms; level inputs drive the flag both ways
   always_comb
   begin
      hw_set = 17'h00000;
      hw_clr = 17'h00000;
      sw_set = 17'h00000;
      sw_clr = 17'h00000;
      hw_set[NIC_FLG_EXT0]  = ext0_edge_select ? ext_fall[0] : !pins_sync[0];                  // R2 R4
      hw_set[NIC_FLG_EXT1]  = ext1_edge_select ? ext_fall[1] : !pins_sync[1];                  // R2 R4
      hw_clr[NIC_FLG_EXT0]  = ext0_edge_select ? clr_ext0 : pins_sync[0];                      // R4
      hw_clr[NIC_FLG_EXT1]  = ext1_edge_select ? clr_ext1 : pins_sync[1];                      // R4
      hw_set[NIC_FLG_T0]    = hw_evt.t0_roll;                                                  // R7
      hw_set[NIC_FLG_T1]    = hw_evt.t1_roll;                                                  // R7
      hw_clr[NIC_FLG_T0]    = clr_t0;                                                          // R8
      hw_clr[NIC_FLG_T1]    = clr_t1;                                                          // R8
      hw_set[NIC_FLG_URX]   = hw_evt.uart_rx;                                                  // R10
      hw_set[NIC_FLG_UTX]   = hw_evt.uart_tx;                                                  // R10
      hw_set[NIC_FLG_TW]    = hw_evt.twowire_evt;                                              // R11
      hw_set[NIC_FLG_ADC]   = hw_evt.adc_done;                                                 // R12
      hw_set[NIC_FLG_SEC]   = hw_evt.one_hz;                                                   // R13
      hw_set[NIC_FLG_CAP3:NIC_FLG_CAP0] = hw_evt.t2_cap | cap_edge;                            // R9 R27
      hw_set[NIC_FLG_CMP2:NIC_FLG_CMP0] = hw_evt.t2_cmp;                                       // R9
      hw_set[NIC_FLG_T2OVF] = hw_evt.t2_ovf;                                                   // R9
      if (sw_wr.wr)
      begin
         // Software set or clear, the completion flag refuses a set
         if (sw_wr.val && sw_wr.sel != NIC_FLG_ADC)
            sw_set[sw_wr.sel] = 1'b1;                                                          // R14 R12
         else if (!sw_wr.val)
            sw_clr[sw_wr.sel] = 1'b1;                                                          // R14
      end
   end

   // Set wins over clear so an event in the clearing cycle survives
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         flags_reg <= `NIC_RST_FLAGS;
      else
         flags_reg <= hw_set | sw_set | (flags_reg & ~(hw_clr | sw_clr));                     // R14
   end

   // ****************************************************************
   // Active level and call outputs
   // ****************************************************************
   // Return clears the highest active level; a call sets its own level
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_hi_reg <= 1'b0;
         act_lo_reg <= 1'b0;
      end
      else if (call_next)
      begin
         if (hi_pick[4])
            act_hi_reg <= 1'b1;
         else
            act_lo_reg <= 1'b1;
      end
      else if (return_from_irq_instr)
      begin
         if (act_hi_reg)
            act_hi_reg <= 1'b0;                                                                // R26
         else
            act_lo_reg <= 1'b0;                                                                // R26
      end
   end

   // One-cycle call pulse with source, level and vector
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hw_long_call_reg <= 1'b0;
         call_info_reg    <= '0;
      end
      else
      begin
         hw_long_call_reg <= call_next;                                                        // R22
         if (call_next)
         begin
            call_info_reg.hi  <= hi_pick[4];
            call_info_reg.src <= pick_src;
            call_info_reg.vec <= VEC_BASE + VEC_STEP * {12'h000, pick_src};                    // R28
         end
      end
   end

   // Wake from idle only for the capable sources, live flags not samples
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         idle_wake_reg <= 1'b0;
      else
         idle_wake_reg <= |(req_now & en_src & `NIC_WAKE_MASK);                                // R15
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_ext0_low4;
      (!ext_zero_request_pin && !ext0_edge_select)[*4];
   endsequence

   property p_call_final;
      hw_long_call_reg |-> $past(cpu_final_cycle) && !$past(cpu_blocking_instr);
   endproperty
   a_call_final: assert property (p_call_final) else $error("call outside final cycle"); // R23

   property p_hi_never_preempted;
      hw_long_call_reg |-> !$past(act_hi_reg);
   endproperty
   a_hi_never_preempted: assert property (p_hi_never_preempted) else $error("high routine preempted"); // R18

   property p_low_same_blocked;
      hw_long_call_reg && !call_info_reg.hi |-> !$past(act_lo_reg);
   endproperty
   a_low_same_blocked: assert property (p_low_same_blocked) else $error("low preempted low"); // R23

   property p_gate_blocks;
      !$past(gate) |-> !hw_long_call_reg;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) else $error("call while gate closed"); // R16

   property p_t0_cleared;
      hw_long_call_reg && call_info_reg.src == `NIC_SRC_T0
         |-> !flags_reg[NIC_FLG_T0] || $past(hw_evt.t0_roll) || $past(sw_set[NIC_FLG_T0]);
   endproperty
   a_t0_cleared: assert property (p_t0_cleared) else $error("timer flag kept on vector"); // R8

   property p_adc_no_sw_set;
      sw_wr.wr && sw_wr.sel == NIC_FLG_ADC && !hw_evt.adc_done && !flags_reg[NIC_FLG_ADC]
         |=> !flags_reg[NIC_FLG_ADC];
   endproperty
   a_adc_no_sw_set: assert property (p_adc_no_sw_set) else $error("software set completion flag"); // R12

   property p_level_follow;
      s_ext0_low4 |-> flags_reg[NIC_FLG_EXT0];
   endproperty
   a_level_follow: assert property (p_level_follow) else $error("level flag not following pin"); // R4

   property p_return_from_irq_instr_hi;
      return_from_irq_instr && act_hi_reg |=> !act_hi_reg;
   endproperty
   a_return_from_irq_instr_hi: assert property (p_return_from_irq_instr_hi) else $error("return left high level active"); // R26

   property p_sample_hold;
      !flag_sample_phase |=> $stable(sample_reg);
   endproperty
   a_sample_hold: assert property (p_sample_hold) else $error("samples changed off strobe"); // R21

   property p_vec_map;
      hw_long_call_reg |-> call_info_reg.vec == 16'(VEC_BASE + VEC_STEP * {12'h000, call_info_reg.src});
   endproperty
   a_vec_map: assert property (p_vec_map) else $error("vector does not match source"); // R28

endmodule

// File: nic_cpu_model.sv
`timescale 1ns/1ps

// ****************************************************************
// CPU core model: cycle strobe, final cycle, service returns
// ****************************************************************
module nic_cpu_model
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Bench controls
   input  wire logic       go,
   input  wire logic       blk,
   input  wire logic [3:0] ret_dly,
   input  wire logic       ret_now,
   // Call from the controller
   input  wire logic       hw_long_call_reg,
   // Timing towards the controller
   output logic            flag_sample_phase,
   output logic            cpu_final_cycle,
   output logic            cpu_blocking_instr,
   output logic            return_from_irq_instr
);
   logic [3:0] cnt_reg; // Cycles left in the routine, 0 means wait for ret_now

   // One machine cycle per clock keeps polling dense, so latency faults show up
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_sample_phase     <= 1'b0;
         cpu_final_cycle       <= 1'b0;
         cpu_blocking_instr    <= 1'b0;
         return_from_irq_instr <= 1'b0;
         cnt_reg               <= 4'h0;
      end
      else
      begin
         flag_sample_phase     <= 1'b1;
         cpu_final_cycle       <= go;
         cpu_blocking_instr    <= blk;
         cnt_reg               <= hw_long_call_reg ? ret_dly : (cnt_reg != 4'h0 ? cnt_reg - 4'h1 : 4'h0);
         return_from_irq_instr <= ret_now | (cnt_reg == 4'h1);
      end
   end
endmodule

// File: testbench.sv
`timescale 1ns/1ps

module testbench;
   import nic_pkg::*;

   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic        clk_sys = 1'b0, rst_n = 1'b0, x0_pin = 1'b1, x0_edge = 1'b1;
   logic [3:0]  cap_pin = 4'hF, cap_rise = 4'h0, cap_fall = 4'h0, ret_dly = 4'h0;
   logic [7:0]  en_a = 8'h00, en_b = 8'h00, lv_a = 8'h00, lv_b = 8'h00;
   nic_hw_evt_s evt = '0;
   nic_sw_wr_s  sw = '0;
   logic        go = 1'b0, blk = 1'b0, ret_now = 1'b0;
   logic        smp, fin, cblk, ret, call, act_hi, act_lo, wake;
   nic_call_s   info;
   logic [16:0] flags;
   int          failures = 0, checks_done = 0;

   always #2.5 clk_sys = ~clk_sys;

   nic_irq_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ext_zero_request_pin(x0_pin),
      .ext_one_request_pin(1'b1), .capture_input_pin(cap_pin), .ext0_edge_select(x0_edge),
      .ext1_edge_select(1'b1), .cap_rise_en(cap_rise), .cap_fall_en(cap_fall), .irq_enable_reg_a(en_a),
      .irq_enable_reg_b(en_b), .irq_level_reg_a(lv_a), .irq_level_reg_b(lv_b), .hw_evt(evt), .sw_wr(sw),
      .flag_sample_phase(smp), .cpu_final_cycle(fin), .cpu_blocking_instr(cblk),
      .return_from_irq_instr(ret), .call_info_reg(info), .hw_long_call_reg(call), .flags_reg(flags),
      .act_hi_reg(act_hi), .act_lo_reg(act_lo), .idle_wake_reg(wake));

   nic_cpu_model cpu_u (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .blk(blk), .ret_dly(ret_dly),
      .ret_now(ret_now), .hw_long_call_reg(call), .flag_sample_phase(smp), .cpu_final_cycle(fin),
      .cpu_blocking_instr(cblk), .return_from_irq_instr(ret));

   // Flag of each poll index; a shared source's second flag is cleared apart
   localparam nic_flag_e FA [15] = '{NIC_FLG_EXT0, NIC_FLG_TW, NIC_FLG_ADC, NIC_FLG_T0, NIC_FLG_CAP0,
      NIC_FLG_CMP0, NIC_FLG_EXT1, NIC_FLG_CAP1, NIC_FLG_CMP1, NIC_FLG_T1, NIC_FLG_CAP2, NIC_FLG_CMP2,
      NIC_FLG_URX, NIC_FLG_CAP3, NIC_FLG_T2OVF};

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Settle past the edge so registered outputs are stable
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic swr(input nic_flag_e f, input logic v);
      @(posedge clk_sys);
      sw <= '{1'b1, f, v};
      @(posedge clk_sys);
      sw <= '0;
   endtask

   // Bounded wait for a call, then judge source, level and vector
   task automatic wait_call(input logic [3:0] s, input logic h);
      int k;
      k = 0;
      #1;
      while (call !== 1'b1 && k < 40)
      begin
         tick(1);
         k++;
      end
      chk("call", 1, call);
      chk("src", s, info.src);
      chk("hi", h, info.hi);
      chk("vec", 16'h0100 + 16'h0008 * s, info.vec);
      tick(1);
   endtask

   task automatic no_call(input int n);
      repeat (n)
      begin
         tick(1);
         chk("no call", 0, call);
      end
   endtask

   task automatic retn();
      @(posedge clk_sys);
      ret_now <= 1'b1;
      @(posedge clk_sys);
      ret_now <= 1'b0;
      tick(1);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // All fifteen sources pending at once, drained in poll order
   task automatic t_order();
      @(posedge clk_sys);
      en_a <= 8'hFF;
      en_b <= 8'hFF;
      for (int i = 0; i < 17; i++)
         if (i != 7) swr(nic_flag_e'(i), 1'b1);
      swr(NIC_FLG_ADC, 1'b1);
      tick(1);
      chk("adc sw set", 0, flags[NIC_FLG_ADC]);
      @(posedge clk_sys);
      evt.adc_done <= 1'b1;
      @(posedge clk_sys);
      evt.adc_done <= 1'b0;
      go <= 1'b1;
      tick(1);
      chk("flags", 17'h1FFFF, flags);
      for (int s = 0; s < 15; s++)
      begin
         wait_call(4'(s), 1'b0);
         chk("hw clear", (s == 0 || s == 3 || s == 6 || s == 9) ? 0 : 1, flags[FA[s]]);
         chk("act lo", 1, act_lo);
         swr(FA[s], 1'b0);
         if (s == 6) swr(NIC_FLG_SEC, 1'b0);
         if (s == 12) swr(NIC_FLG_UTX, 1'b0);
         retn();
         chk("ret lo", 0, act_lo);
      end
   endtask

   // Preemption, gate, blocking instruction and idle wake
   task automatic t_prio();
      @(posedge clk_sys);
      en_a <= 8'h7F;
      lv_a <= 8'h01;
      lv_b <= 8'h80;
      swr(NIC_FLG_CAP3, 1'b1);
      no_call(4);
      chk("wake cap3", 0, wake);
      @(posedge clk_sys);
      en_a <= 8'hFF;
      wait_call(4'hD, 1'b0);
      swr(NIC_FLG_T2OVF, 1'b1);
      wait_call(4'hE, 1'b1);
      swr(NIC_FLG_EXT0, 1'b1);
      no_call(6);
      chk("wake ext0", 1, wake);
      @(posedge clk_sys);
      en_a <= 8'h7F;
      blk <= 1'b1;
      retn();
      chk("ret hi", 0, act_hi);
      no_call(6);
      @(posedge clk_sys);
      en_a <= 8'hFF;
      no_call(6);
      @(posedge clk_sys);
      blk <= 1'b0;
      wait_call(4'h0, 1'b1);
      swr(NIC_FLG_CAP3, 1'b0);
      swr(NIC_FLG_T2OVF, 1'b0);
      retn();
      retn();
      chk("idle", 0, {act_hi, act_lo});
   endtask

   // Level pin held low, released inside the routine; capture pin edge
   task automatic t_level();
      @(posedge clk_sys);
      x0_edge <= 1'b0;
      en_a <= 8'h81;
      lv_a <= 8'h00;
      x0_pin <= 1'b0;
      wait_call(4'h0, 1'b0);
      tick(2);
      chk("level held", 1, flags[NIC_FLG_EXT0]);
      @(posedge clk_sys);
      x0_pin <= 1'b1;
      tick(4);
      chk("level drop", 0, flags[NIC_FLG_EXT0]);
      retn();
      no_call(4);
      @(posedge clk_sys);
      cap_rise <= 4'h2;
      cap_fall <= 4'h1;
      cap_pin <= 4'hC;
      tick(5);
      chk("cap fall", 1, flags[NIC_FLG_CAP0]);
      chk("cap no rise", 0, flags[NIC_FLG_CAP1]);
      @(posedge clk_sys);
      cap_pin <= 4'hE;
      tick(5);
      chk("cap rise", 1, flags[NIC_FLG_CAP1]);
   endtask

   // ****************************************************************
   // Run control
   // ****************************************************************
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      tick(2);
      t_order();
      t_prio();
      t_level();
      test_done();
   end

   // Whole run needs a few hundred cycles; this bound is well past that
   initial
   begin
      #50us;
      failures++;
      test_done();
   end
endmodule
